// ===== bench/mirq_inst_model.sv
`timescale 1ns/1ps
// Behavioural instruments: each answers a routed query after its own delay.
module mirq_inst_model #(
	parameter int LAT = 6
) (
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic [2:0]  inst_cmd_valid,
	input  wire logic [15:0] inst_cmd_arg,
	input  wire logic        inst_cmd_query,
	output logic      [2:0]  inst_busy,
	output logic             ans_valid,
	output logic      [1:0]  ans_inst,
	output logic      [15:0] ans_val
);
	int   cnt [3];           // Cycles left per instrument, 1 = ready.
	logic [15:0] val [3];    // Answer held until the shared port is free.

	// Slower instruments keep running while another one is addressed.
	// Only one answer per cycle leaves, lowest index first.
	always_ff @(posedge ref_clk) begin
		logic hit;
		ans_valid <= 1'b0;
		ans_val   <= ~ans_val;
		hit = 1'b0;
		if (!rst_n) begin
			inst_busy <= 3'h0;
			ans_val   <= 16'h0000;
			ans_inst  <= 2'h0;
			for (int i = 0; i < 3; i++) cnt[i] <= 0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (inst_cmd_valid[i] && inst_cmd_query) begin
					cnt[i]       <= LAT + 3 * i;
					val[i]       <= inst_cmd_arg ^ 16'h00FF;
					inst_busy[i] <= 1'b1;
				end else if (cnt[i] > 1) begin
					cnt[i] <= cnt[i] - 1;
				end else if (cnt[i] == 1 && !hit) begin
					hit = 1'b1;
					cnt[i]       <= 0;
					inst_busy[i] <= 1'b0;
					ans_valid    <= 1'b1;
					ans_inst     <= 2'(i);
					ans_val      <= val[i];
				end
			end
		end
	end
endmodule

// ===== bench/tb_multi_instrument_response_queue.sv
`timescale 1ns/1ps
// Drives commands and reads; a negedge monitor checks every read word.
module tb_multi_instrument_response_queue;
	logic ref_clk = 0, rst_n = 0, cmd_valid = 0, cmd_query = 0, cmd_end = 0;
	logic rd_req = 0, rd_ready = 0;
	mirq_pkg::mirq_op_e cmd_op = mirq_pkg::OP_GLOBAL;
	logic [15:0] cmd_arg = 16'h0000, ans_val, inst_cmd_arg, err_code;
	logic [15:0] last_err = 16'h0000, a;
	logic [2:0]  inst_cmd_valid, inst_busy, hot = 3'h0;
	logic [1:0]  ans_inst;
	logic [29:0] rd_data;
	logic cmd_ready, inst_cmd_query, ans_valid, rd_valid, rd_last;
	logic err_valid, async_mode, opc_done;
	mirq_pkg::mirq_op_e inst_cmd_op;
	int error_cnt = 0, n_tests = 0, seed = 5, k, tmp;
	logic [30:0] exp_q [$];  // Expected {last, inst, seq, value} words.

	mirq_core dut (.ref_clk(ref_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_arg(cmd_arg),
		.cmd_query(cmd_query), .cmd_end(cmd_end),
		.inst_cmd_valid(inst_cmd_valid), .inst_cmd_op(inst_cmd_op),
		.inst_cmd_arg(inst_cmd_arg), .inst_cmd_query(inst_cmd_query),
		.inst_busy(inst_busy), .ans_valid(ans_valid), .ans_inst(ans_inst),
		.ans_val(ans_val), .rd_req(rd_req), .rd_valid(rd_valid),
		.rd_ready(rd_ready), .rd_data(rd_data), .rd_last(rd_last),
		.err_valid(err_valid), .err_code(err_code),
		.async_mode(async_mode), .opc_done(opc_done));
	mirq_inst_model u_inst (.ref_clk(ref_clk), .rst_n(rst_n),
		.inst_cmd_valid(inst_cmd_valid), .inst_cmd_arg(inst_cmd_arg),
		.inst_cmd_query(inst_cmd_query), .inst_busy(inst_busy),
		.ans_valid(ans_valid), .ans_inst(ans_inst), .ans_val(ans_val));

	initial forever #25 ref_clk = ~ref_clk;

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task end_sim;
		$display("tests=%0d errors=%0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	// A wait that ran out is a mismatch and closes the run.
	task tmo;
		chk(32'h0000_0001, 32'h0000_0000);
		end_sim;
	endtask

	task push(input logic [1:0] n, input logic [11:0] s,
		input logic [15:0] v, input logic l);
		exp_q.push_back({l, n, s, v});
	endtask

	// Offers one single-unit message and holds it until taken.
	task cmd(input mirq_pkg::mirq_op_e op, input logic [15:0] arg,
		input logic q);
		@(posedge ref_clk);
		#1 {cmd_valid, cmd_op, cmd_arg, cmd_query, cmd_end} = {1'b1, op, arg, q, 1'b1};
		k = 0;
		while (!cmd_ready && k < 200) begin
			@(posedge ref_clk);
			#1 k++;
		end
		if (k == 200) tmo;
		@(posedge ref_clk);
		#1 cmd_valid = 0;
	endtask

	// One bus read; returns when every expected word has arrived.
	task rd;
		@(posedge ref_clk);
		#1 rd_req = 1;
		@(posedge ref_clk);
		#1 rd_req = 0;
		k = 0;
		while (exp_q.size() > 0 && k < 200) begin
			@(posedge ref_clk);
			k++;
		end
		if (k == 200) tmo;
		repeat (3) @(posedge ref_clk);
	endtask

	// Random stalls by the reader; words must survive them.
	always @(posedge ref_clk) begin
		tmp = $random(seed);
		#1 rd_ready = tmp[0];
	end

	// Sampled at the falling edge, where registered outputs are settled.
	always @(negedge ref_clk) begin
		if (err_valid === 1'b1) last_err = err_code;
		if (inst_cmd_valid !== 3'h0) hot = inst_cmd_valid;
		if (rst_n && rd_valid === 1'b1 && rd_ready === 1'b1) begin
			if (exp_q.size() == 0) chk({1'b1, rd_last, rd_data}, 0);
			else chk({rd_last, rd_data}, exp_q.pop_front());
		end
	end

	initial begin
		repeat (12) @(posedge ref_clk);
		#1 rst_n = 1;
		chk(async_mode, 0);
		cmd(mirq_pkg::OP_COUNT, 16'h0000, 1);
		repeat (5) @(posedge ref_clk);
		chk(cmd_ready, 0);
		push(0, 0, mirq_pkg::INST_COUNT, 1);
		rd();
		rd();
		repeat (20) @(posedge ref_clk);
		cmd(mirq_pkg::OP_SNUM, 16'h0000, 0);
		repeat (3) @(posedge ref_clk);
		chk(last_err, mirq_pkg::ERR_SETTINGS);
		cmd(mirq_pkg::OP_LANG, 16'h0001, 0);
		repeat (3) @(posedge ref_clk);
		chk(async_mode, 1);
		push(0, mirq_pkg::SEQ_EMPTY, mirq_pkg::VAL_EMPTY, 1);
		rd();
		// Nine answers into seven free slots: two are dropped.
		for (int i = 1; i <= 9; i++) cmd(mirq_pkg::OP_COUNT, 16'h0000, 1);
		repeat (4) @(posedge ref_clk);
		push(0, mirq_pkg::SEQ_OVF, mirq_pkg::VAL_OVF, 1);
		rd();
		for (int i = 1; i <= 7; i++) begin
			push(0, i[11:0], mirq_pkg::INST_COUNT, 1);
			rd();
		end
		cmd(mirq_pkg::OP_SEL_NUM, 16'h0002, 0);
		a = 16'($random(seed));
		cmd(mirq_pkg::OP_INST, a, 1);
		repeat (3) @(posedge ref_clk);
		chk(hot, 3'b010);
		k = 0;
		while (inst_busy !== 3'h0 && k < 200) begin
			@(posedge ref_clk);
			k++;
		end
		if (k == 200) tmo;
		repeat (3) @(posedge ref_clk);
		push(2, 10, a ^ 16'h00FF, 1);
		rd();
		cmd(mirq_pkg::OP_QUEUE_READ_MODE, 16'h0001, 0);
		cmd(mirq_pkg::OP_COUNT, 16'h0000, 1);
		cmd(mirq_pkg::OP_COUNT, 16'h0000, 1);
		repeat (4) @(posedge ref_clk);
		push(0, 11, mirq_pkg::INST_COUNT, 0);
		push(0, 12, mirq_pkg::INST_COUNT, 1);
		rd();
		cmd(mirq_pkg::OP_CAT, 16'h0000, 1);
		repeat (4) @(posedge ref_clk);
		push(0, 13, mirq_pkg::INST_MASK, 1);
		rd();
		cmd(mirq_pkg::OP_SEL_NAME, 16'h1234, 0);
		repeat (3) @(posedge ref_clk);
		chk(last_err, mirq_pkg::ERR_ILLEGAL);
		cmd(mirq_pkg::OP_SEL_NAME, mirq_pkg::INST_NAMES[2], 0);
		cmd(mirq_pkg::OP_INST, 16'h0000, 0);
		repeat (3) @(posedge ref_clk);
		chk(hot, 3'b100);
		chk(inst_cmd_op, mirq_pkg::OP_INST);
		cmd(mirq_pkg::OP_SYNC, 16'h0001, 0);
		repeat (3) @(posedge ref_clk);
		chk(opc_done, 1);
		end_sim;
	end
endmodule

// ===== design/mirq_core.sv
`timescale 1ns/1ps
// Notes on behaviour
// [RQ1] Reset starts in strict exchange mode.
// [RQ2] Global commands ignore which instrument is active.
// [RQ3] One active instrument; others keep running.
// [RQ4] Answer configuration queries; select by name/number.
// [RQ5] Strict: nothing accepted until response read.
// [RQ6] Strict read with nothing buffered gets no answer.
// [RQ7] Strict compound query gives one ordered message.
// [RQ8] Asynchronous responses queue, read out in order.
// [RQ9] One queue slot always kept for overflow notice.
// [RQ10] Full queue drops new responses, parser never stalls.
// [RQ11] After a drop, next read gives overflow notice.
// [RQ12] Stored responses stay unaltered until read.
// [RQ13] Asynchronous sync commands wait on all instruments.
// [RQ14] Host should keep one mode until reset.
// [RQ15] Asynchronous read of empty queue gives empty notice.
// [RQ16] Next mode one entry; all mode drains queue.
// [RQ17] Sequence counter tags queries, then counts up.
// [RQ18] Asynchronous-only commands in strict mode raise -210.
// [RQ19] Queue depth is a design constant, at least two.
// [RQ20] Selections take effect from the next command.
module mirq_core (
	input  wire logic                             ref_clk,
	input  wire logic                             rst_n,
	input  wire logic                             cmd_valid,
	output logic                                  cmd_ready,
	input  wire mirq_pkg::mirq_op_e               cmd_op,
	input  wire logic [15:0]                      cmd_arg,
	input  wire logic                             cmd_query,
	input  wire logic                             cmd_end,
	output logic [mirq_pkg::NUM_INST-1:0]         inst_cmd_valid,
	output mirq_pkg::mirq_op_e                    inst_cmd_op,
	output logic [15:0]                           inst_cmd_arg,
	output logic                                  inst_cmd_query,
	input  wire logic [mirq_pkg::NUM_INST-1:0]    inst_busy,
	input  wire logic                             ans_valid,
	input  wire logic [mirq_pkg::INST_W-1:0]      ans_inst,
	input  wire logic [mirq_pkg::VAL_W-1:0]       ans_val,
	input  wire logic                             rd_req,
	output logic                                  rd_valid,
	input  wire logic                             rd_ready,
	output logic [mirq_pkg::ENT_W-2:0]            rd_data,
	output logic                                  rd_last,
	output logic                                  err_valid,
	output logic [15:0]                           err_code,
	output logic                                  async_mode,
	output logic                                  opc_done
);

	// Registered state and its next value.
	mirq_pkg::mirq_state_s s_reg;
	mirq_pkg::mirq_state_s s_next;

	// Helper terms shared by the assertions.
	logic acc;        // A command is taken this cycle.
	logic push_try;   // A response wants a queue slot.
	logic space;      // The output buffer can take a word.

	assign acc   = cmd_valid && s_reg.cmd_rdy;
	assign space = !s_reg.ob_v1;
	assign push_try = ans_valid || s_reg.ip_v;

	// All next-state logic: output buffer, read engine, queue, parser.
	always_comb begin
		logic                             push;
		logic                             pop;
		logic [mirq_pkg::ENT_W-1:0]       pent;
		logic                             oin_v;
		logic [mirq_pkg::ENT_W-1:0]       oin;
		logic [mirq_pkg::ENT_W-1:0]       head;
		logic                             strict_done;
		logic                             found;
		logic [mirq_pkg::INST_W-1:0]      fidx;
		logic                             aonly;
		push = 1'b0;
		pop = 1'b0;
		pent = '0;
		oin_v = 1'b0;
		oin = '0;
		head = s_reg.q[s_reg.hd];
		strict_done = 1'b0;
		found = 1'b0;
		fidx = '0;
		aonly = 1'b0;
		s_next = s_reg;
		s_next.err_v = 1'b0;
		s_next.icv = '0;

		// The host drains the head word; the second slot moves up.
		if (s_reg.ob_v0 && rd_ready) begin
			s_next.ob_v0 = s_reg.ob_v1;
			s_next.ob_d0 = s_reg.ob_d1;
			s_next.ob_v1 = 1'b0;
		end

		// Read engine: a request is latched, then served when room exists.
		case (s_reg.rst)
			mirq_pkg::R_IDLE: begin
				if (rd_req) begin
					s_next.rst = mirq_pkg::R_START;
				end
			end
			mirq_pkg::R_START: begin
				if (!s_reg.async) begin
					// Nothing buffered: the read is dropped, bus times out.
					if (s_reg.cnt == '0) begin
						s_next.rst = mirq_pkg::R_IDLE; // RQ6
					end else begin
						s_next.rst = mirq_pkg::R_SEND;
					end
				end else if (space) begin
					if (s_reg.ovf) begin
						oin_v = 1'b1; // RQ11
						oin = {1'b1, {mirq_pkg::INST_W{1'b0}},
							mirq_pkg::SEQ_OVF, mirq_pkg::VAL_OVF};
						s_next.rst = mirq_pkg::R_IDLE;
					end else if (s_reg.cnt == '0) begin
						oin_v = 1'b1; // RQ15
						oin = {1'b1, {mirq_pkg::INST_W{1'b0}},
							mirq_pkg::SEQ_EMPTY, mirq_pkg::VAL_EMPTY};
						s_next.rst = mirq_pkg::R_IDLE;
					end else begin
						s_next.rst = mirq_pkg::R_SEND;
					end
				end
			end
			mirq_pkg::R_SEND: begin
				// Entries leave in arrival order, head first.
				if (space && s_reg.cnt != '0) begin
					pop = 1'b1; // RQ8
					oin_v = 1'b1;
					oin = head;
					if (!s_reg.async) begin
						// Strict: the whole combined message goes out.
						if (head[mirq_pkg::ENT_LAST]) begin
							s_next.rst = mirq_pkg::R_IDLE; // RQ7
							strict_done = 1'b1;
						end
					end else if (!s_reg.all_mode || s_reg.cnt == mirq_pkg::CNT_ONE) begin
						oin[mirq_pkg::ENT_LAST] = 1'b1; // RQ16
						s_next.rst = mirq_pkg::R_IDLE;
					end else begin
						oin[mirq_pkg::ENT_LAST] = 1'b0; // RQ16
					end
				end
			end
			default: begin
				s_next.rst = mirq_pkg::R_IDLE;
			end
		endcase

		// A word entering the buffer lands in the first free slot.
		if (oin_v) begin
			if (!s_next.ob_v0) begin
				s_next.ob_v0 = 1'b1;
				s_next.ob_d0 = oin;
			end else begin
				s_next.ob_v1 = 1'b1;
				s_next.ob_d1 = oin;
			end
		end

		// Instrument answers win the write port; card answers wait until no instrument answer arrives.
		if (ans_valid) begin
			push = 1'b1;
			pent = {!s_reg.async ? s_reg.pend[ans_inst] : 1'b1,
				ans_inst + 2'h1, s_reg.pseq[ans_inst], ans_val};
		end else if (s_reg.ip_v) begin
			push = 1'b1;
			pent = s_reg.ip;
			s_next.ip_v = 1'b0;
		end

		// Stored entries are never touched; a full queue drops the newcomer.
		if (pop) begin
			s_next.hd = s_reg.hd + mirq_pkg::PTR_ONE;
		end
		if (push && s_reg.cnt >= mirq_pkg::CNT_FULL && !pop) begin
			s_next.ovf = 1'b1; // RQ10
			push = 1'b0; // RQ9
		end
		if (push) begin
			s_next.q[s_reg.tl] = pent; // RQ12
			s_next.tl = s_reg.tl + mirq_pkg::PTR_ONE; // RQ19
		end
		if (push && !pop) begin
			s_next.cnt = s_reg.cnt + mirq_pkg::CNT_ONE;
		end else if (pop && !push) begin
			s_next.cnt = s_reg.cnt - mirq_pkg::CNT_ONE;
		end
		// The drop flag, once raised, clears only when its notice is sent.
		if (s_reg.rst == mirq_pkg::R_START && s_reg.async && space &&
			s_reg.ovf && !s_next.ovf) begin
			s_next.ovf = 1'b0;
		end else if (s_reg.rst == mirq_pkg::R_START && s_reg.async &&
			space && s_reg.ovf && !(push_try && s_reg.cnt >= mirq_pkg::CNT_FULL)) begin
			s_next.ovf = 1'b0; // RQ11
		end

		// Parser: takes one command when ready.
		case (s_reg.pst)
			mirq_pkg::P_IDLE: begin
				if (acc) begin
					aonly = (cmd_op == mirq_pkg::OP_QUEUE_READ_MODE) ||
						(cmd_op == mirq_pkg::OP_SNUM);
					if (cmd_query) begin
						s_next.seq = s_reg.seq + mirq_pkg::SEQ_ONE; // RQ17
					end
					s_next.ip = {cmd_end, {mirq_pkg::INST_W{1'b0}},
						s_reg.seq, {mirq_pkg::VAL_W{1'b0}}};
					if (!s_reg.async && aonly) begin
						s_next.err_v = 1'b1; // RQ18
						s_next.err_c = mirq_pkg::ERR_SETTINGS;
					end else begin
						case (cmd_op)
							mirq_pkg::OP_INST: begin
								// Only the active one sees it; others run on.
								for (int i = 0; i < mirq_pkg::NUM_INST; i++) begin
									s_next.icv[i] = (s_reg.act == mirq_pkg::INST_W'(i)); // RQ3
								end
								s_next.iop = cmd_op;
								s_next.iarg = cmd_arg;
								s_next.iqry = cmd_query;
								if (cmd_query) begin
									s_next.pseq[s_reg.act] = s_reg.seq;
									s_next.pend[s_reg.act] = cmd_end;
									if (!s_reg.async) begin
										s_next.pst = mirq_pkg::P_WAIT_ANS; // RQ5
									end
								end
							end
							mirq_pkg::OP_SEL_NAME: begin
								for (int i = 0; i < mirq_pkg::NUM_INST; i++) begin
									if (cmd_arg == mirq_pkg::INST_NAMES[i]) begin
										found = 1'b1;
										fidx = mirq_pkg::INST_W'(i);
									end
								end
								if (found) begin
									s_next.act = fidx; // RQ4 RQ20
								end else begin
									s_next.err_v = 1'b1;
									s_next.err_c = mirq_pkg::ERR_ILLEGAL;
								end
							end
							mirq_pkg::OP_SEL_NUM: begin
								if (cmd_arg != 16'h0000 && cmd_arg <= mirq_pkg::INST_COUNT) begin
									s_next.act = cmd_arg[mirq_pkg::INST_W-1:0] - 2'h1; // RQ4
								end else begin
									s_next.err_v = 1'b1;
									s_next.err_c = mirq_pkg::ERR_ILLEGAL;
								end
							end
							mirq_pkg::OP_CAT: begin
								s_next.ip[mirq_pkg::VAL_W-1:0] = mirq_pkg::INST_MASK; // RQ4
							end
							mirq_pkg::OP_COUNT: begin
								s_next.ip[mirq_pkg::VAL_W-1:0] = mirq_pkg::INST_COUNT; // RQ4
							end
							mirq_pkg::OP_LANG: begin
								if (cmd_query) begin
									s_next.ip[0] = s_reg.async;
								end else begin
									s_next.async = cmd_arg[0]; // RQ20
								end
							end
							mirq_pkg::OP_QUEUE_READ_MODE: begin
								if (cmd_query) begin
									s_next.ip[0] = s_reg.all_mode;
								end else begin
									s_next.all_mode = cmd_arg[0]; // RQ16
								end
							end
							mirq_pkg::OP_SNUM: begin
								// The answer names the tag the next query gets.
								if (cmd_query) begin
									s_next.ip[mirq_pkg::SEQ_W-1:0] = s_next.seq;
								end else begin
									s_next.seq = cmd_arg[mirq_pkg::SEQ_W-1:0]; // RQ17
								end
							end
							mirq_pkg::OP_SYNC: begin
								// Waits on every instrument, not just the active.
								s_next.sync_kind = cmd_arg[1:0];
								s_next.sync_end = cmd_end;
								s_next.sync_seq = s_reg.seq;
								s_next.pst = mirq_pkg::P_WAIT_SYNC; // RQ13
							end
							default: begin
							end
						endcase
						// Card-level answers are identical for any active one.
						if (cmd_query && cmd_op != mirq_pkg::OP_INST &&
							cmd_op != mirq_pkg::OP_SYNC) begin
							s_next.ip_v = 1'b1; // RQ2
							if (!s_reg.async && cmd_end) begin
								s_next.pst = mirq_pkg::P_WAIT_READ; // RQ5
							end
						end
					end
				end
			end
			mirq_pkg::P_WAIT_ANS: begin
				if (ans_valid) begin
					s_next.pst = s_reg.pend[ans_inst] ? mirq_pkg::P_WAIT_READ :
						mirq_pkg::P_IDLE; // RQ7
				end
			end
			mirq_pkg::P_WAIT_SYNC: begin
				if (inst_busy == '0) begin
					s_next.pst = mirq_pkg::P_IDLE;
					if (s_reg.sync_kind == mirq_pkg::SYNC_OPC) begin
						s_next.opc = 1'b1;
					end else if (s_reg.sync_kind == mirq_pkg::SYNC_OPCQ) begin
						s_next.ip_v = 1'b1; // RQ13
						s_next.ip = {s_reg.sync_end, {mirq_pkg::INST_W{1'b0}},
							s_reg.sync_seq, 16'h0001};
						if (!s_reg.async && s_reg.sync_end) begin
							s_next.pst = mirq_pkg::P_WAIT_READ;
						end
					end
				end
			end
			mirq_pkg::P_WAIT_READ: begin
				// Strict: released once the last word of the message has left the queue.
				if (strict_done || s_reg.async) begin
					s_next.pst = mirq_pkg::P_IDLE; // RQ5
				end
			end
			default: begin
				s_next.pst = mirq_pkg::P_IDLE;
			end
		endcase

		// Ready drops for a cycle after each take, so one command per cycle pair.
		s_next.cmd_rdy = (s_next.pst == mirq_pkg::P_IDLE) && !s_next.ip_v && !acc;
	end

	// State register; reset restores strict exchange and clears the counter.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			s_reg <= '0; // RQ1
			s_reg.pst <= mirq_pkg::P_IDLE;
			s_reg.rst <= mirq_pkg::R_IDLE;
			s_reg.seq <= mirq_pkg::SEQ_RST;
			s_reg.iop <= mirq_pkg::OP_GLOBAL;
		end else begin
			s_reg <= s_next;
		end
	end

	// Every output is a field of the state register.
	assign cmd_ready      = s_reg.cmd_rdy;
	assign inst_cmd_valid = s_reg.icv;
	assign inst_cmd_op    = s_reg.iop;
	assign inst_cmd_arg   = s_reg.iarg;
	assign inst_cmd_query = s_reg.iqry;
	assign rd_valid       = s_reg.ob_v0;
	assign rd_data        = s_reg.ob_d0[mirq_pkg::ENT_W-2:0];
	assign rd_last        = s_reg.ob_d0[mirq_pkg::ENT_LAST];
	assign err_valid      = s_reg.err_v;
	assign err_code       = s_reg.err_c;
	assign async_mode     = s_reg.async;
	assign opc_done       = s_reg.opc;

	property p_reset_strict;
		@(posedge ref_clk) !rst_n |=> !async_mode && !s_reg.all_mode;
	endproperty
	a_reset_strict: assert property (p_reset_strict) // RQ1
		else $error("Not strict mode after reset.");

	property p_strict_block;
		@(posedge ref_clk) disable iff (!rst_n)
		s_reg.pst == mirq_pkg::P_WAIT_READ && !async_mode |-> !cmd_ready;
	endproperty
	a_strict_block: assert property (p_strict_block) // RQ5
		else $error("Command taken before strict response read.");

	property p_strict_silent;
		@(posedge ref_clk) disable iff (!rst_n)
		s_reg.rst == mirq_pkg::R_START && !async_mode && s_reg.cnt == '0 &&
		!rd_valid && !push_try |=> !rd_valid [*2];
	endproperty
	a_strict_silent: assert property (p_strict_silent) // RQ6
		else $error("Strict read answered with nothing buffered.");

	property p_reserved_slot;
		@(posedge ref_clk) disable iff (!rst_n)
		s_reg.cnt <= mirq_pkg::CNT_FULL;
	endproperty
	a_reserved_slot: assert property (p_reserved_slot) // RQ9
		else $error("Queue used its reserved slot.");

	property p_drop_flag;
		@(posedge ref_clk) disable iff (!rst_n)
		push_try && s_reg.cnt == mirq_pkg::CNT_FULL &&
		s_reg.rst != mirq_pkg::R_SEND |=> s_reg.ovf && $stable(s_reg.cnt);
	endproperty
	a_drop_flag: assert property (p_drop_flag) // RQ10
		else $error("Full queue did not drop and flag.");

	property p_ovf_notice;
		@(posedge ref_clk) disable iff (!rst_n)
		s_reg.rst == mirq_pkg::R_START && async_mode && s_reg.ovf && space &&
		!rd_valid |=> rd_valid && rd_last &&
		rd_data[mirq_pkg::INST_LSB-1:mirq_pkg::SEQ_LSB] == mirq_pkg::SEQ_OVF;
	endproperty
	a_ovf_notice: assert property (p_ovf_notice) // RQ11
		else $error("Overflow notice not delivered.");

	property p_empty_notice;
		@(posedge ref_clk) disable iff (!rst_n)
		s_reg.rst == mirq_pkg::R_START && async_mode && !s_reg.ovf &&
		s_reg.cnt == '0 && space && !rd_valid |=> rd_valid && rd_last &&
		rd_data[mirq_pkg::VAL_W-1:0] == mirq_pkg::VAL_EMPTY;
	endproperty
	a_empty_notice: assert property (p_empty_notice) // RQ15
		else $error("Empty read did not return the empty notice.");

	property p_seq_step;
		@(posedge ref_clk) disable iff (!rst_n)
		acc && cmd_query |=> s_reg.seq == $past(s_reg.seq) + mirq_pkg::SEQ_ONE;
	endproperty
	a_seq_step: assert property (p_seq_step) // RQ17
		else $error("Sequence counter did not step on a query.");

	property p_conflict;
		@(posedge ref_clk) disable iff (!rst_n)
		acc && !async_mode && (cmd_op == mirq_pkg::OP_QUEUE_READ_MODE ||
		cmd_op == mirq_pkg::OP_SNUM) |=> err_valid &&
		err_code == mirq_pkg::ERR_SETTINGS && inst_cmd_valid == '0;
	endproperty
	a_conflict: assert property (p_conflict) // RQ18
		else $error("Missing settings conflict error.");

	property p_one_active;
		@(posedge ref_clk) disable iff (!rst_n)
		$onehot0(inst_cmd_valid);
	endproperty
	a_one_active: assert property (p_one_active) // RQ3
		else $error("More than one instrument commanded.");

endmodule

// ===== design/mirq_pkg.sv
package mirq_pkg;

	// Sizes of the card and of the response path.
	localparam int NUM_INST = 3;             // Instruments behind the card.
	localparam int INST_W   = 2;             // Instrument index / number width.
	localparam int Q_DEPTH  = 8;             // Response queue entries.
	localparam int Q_AW     = 3;             // Queue pointer width.
	localparam int SEQ_W    = 12;            // Query sequence counter width.
	localparam int VAL_W    = 16;            // Response value width.
	localparam int ENT_W    = 1 + INST_W + SEQ_W + VAL_W;
	localparam int Q_USABLE = Q_DEPTH - 1;   // One slot kept for the notice.

	// Field positions of one queue entry.
	localparam int ENT_LAST = ENT_W - 1;     // Closes a combined message.
	localparam int INST_LSB = SEQ_W + VAL_W; // Instrument number, 0 = card.
	localparam int SEQ_LSB  = VAL_W;         // Sequence tag.

	// Counter steps, reset values and the queue full limit.
	localparam logic [Q_AW:0]    CNT_ONE  = 4'h1;
	localparam logic [Q_AW-1:0]  PTR_ONE  = 3'h1;
	localparam logic [SEQ_W-1:0] SEQ_ONE  = 12'h001;
	localparam logic [SEQ_W-1:0] SEQ_RST  = 12'h000;
	localparam logic [Q_AW:0]    CNT_FULL = 4'h7;

	// Tags and values of the two fixed notices.
	localparam logic [SEQ_W-1:0] SEQ_EMPTY = 12'hFFF;  // Tag -1.
	localparam logic [SEQ_W-1:0] SEQ_OVF   = 12'hFFE;  // Tag -2.
	localparam logic [VAL_W-1:0] VAL_EMPTY = 16'h0001; // Arbitrary code.
	localparam logic [VAL_W-1:0] VAL_OVF   = 16'h0002; // Arbitrary code.

	// Error codes, two's complement of the decimal code.
	localparam logic [15:0] ERR_SETTINGS = 16'hFF2E;   // -210.
	localparam logic [15:0] ERR_ILLEGAL  = 16'hFF20;   // -224.

	// Installed-instrument answers and name codes (arbitrary values).
	localparam logic [VAL_W-1:0] INST_MASK  = 16'h0007;
	localparam logic [VAL_W-1:0] INST_COUNT = 16'h0003;
	localparam logic [NUM_INST-1:0][15:0] INST_NAMES =
		{16'h0C03, 16'h0C02, 16'h0C01};

	// Synchronisation argument codes.
	localparam logic [1:0] SYNC_WAI  = 2'h0;
	localparam logic [1:0] SYNC_OPC  = 2'h1;
	localparam logic [1:0] SYNC_OPCQ = 2'h2;

	// Pre-parsed command codes.
	typedef enum logic [3:0] {
		OP_INST     = 4'h0, // Instrument class, goes to the active one.
		OP_SEL_NAME = 4'h1, // Select active instrument by name code.
		OP_SEL_NUM  = 4'h2, // Select active instrument by number.
		OP_CAT      = 4'h3, // Catalogue query.
		OP_COUNT    = 4'h4, // Instrument count query.
		OP_LANG     = 4'h5, // Strict or asynchronous exchange.
		OP_QUEUE_READ_MODE    = 4'h6, // Queue read mode, next or all.
		OP_SNUM     = 4'h7, // Load or read the sequence counter.
		OP_SYNC     = 4'h8, // Wait, complete, complete query.
		OP_GLOBAL   = 4'h9  // Other global command, no effect here.
	} mirq_op_e;

	// Command parser states, Gray in listed order; idle and sync wait differ in both bits.
	typedef enum logic [1:0] {
		P_IDLE      = 2'b00,
		P_WAIT_ANS  = 2'b01,
		P_WAIT_SYNC = 2'b11,
		P_WAIT_READ = 2'b10
	} mirq_pst_e;

	// Read engine states.
	typedef enum logic [1:0] {
		R_IDLE  = 2'b00,
		R_START = 2'b01,
		R_SEND  = 2'b11
	} mirq_rst_e;

	// Whole state of the core.
	typedef struct packed {
		mirq_pst_e                         pst;
		mirq_rst_e                         rst;
		logic                              async;
		logic                              all_mode;
		logic                              ovf;
		logic [INST_W-1:0]                 act;
		logic [SEQ_W-1:0]                  seq;
		logic [1:0]                        sync_kind;
		logic                              sync_end;
		logic [SEQ_W-1:0]                  sync_seq;
		logic [Q_DEPTH-1:0][ENT_W-1:0]     q;
		logic [Q_AW-1:0]                   hd;
		logic [Q_AW-1:0]                   tl;
		logic [Q_AW:0]                     cnt;
		logic                              ip_v;
		logic [ENT_W-1:0]                  ip;
		logic [NUM_INST-1:0][SEQ_W-1:0]    pseq;
		logic [NUM_INST-1:0]               pend;
		logic                              ob_v0;
		logic                              ob_v1;
		logic [ENT_W-1:0]                  ob_d0;
		logic [ENT_W-1:0]                  ob_d1;
		logic                              cmd_rdy;
		logic [NUM_INST-1:0]               icv;
		mirq_op_e                          iop;
		logic [15:0]                       iarg;
		logic                              iqry;
		logic                              err_v;
		logic [15:0]                       err_c;
		logic                              opc;
	} mirq_state_s;

endpackage
